// File: tcc_regs.v
// Capture/compare register set for timers 1 and 3, with the timer 1
// capture and match A/B flags, their interrupt masks and requests.
// Assumes counters, prescalers and waveform logic live outside and feed
// counter values and one-cycle tick enables; all inputs are synchronous.
//
// Summary of operation
// RL1 - Pin edge copies counter into capture register.
// RL2 - Timer 1 may capture on comparator output.
// RL3 - Capture register can serve as counter top.
// RL4 - Capture bytes read as one coherent snapshot.
// RL5 - One shared high-byte latch for all 16-bit registers.
// RL6 - Mask bit 5 enables capture interrupt request.
// RL7 - Mask bit 4 enables match A request.
// RL8 - Mask bit 3 enables match B request.
// RL9 - Low registers at offset, data space +0x20.
// RL10 - Extended registers reachable by data space only.
// RL11 - All byte registers reset to zero.
// RL12 - Mask register at I/O 0x37, data 0x57.
// RL13 - Timer 1 capture at I/O 0x26/0x27.
// RL14 - Capture flag set on event, cleared by vector/write-one.
// RL15 - Match flag set tick after equality.
// RL16 - Counter write suppresses next-tick match.
// RL17 - High byte first; low read latches high.
`timescale 1ns/1ps
`default_nettype none
`include "tcc_defs.vh"

module tcc_regs #(
  parameter W = 16
) (
  // Clock and reset.
  input  wire         clock_in,
  input  wire         nrst_in,
  // Processor I/O bus.
  input  wire         io_rd_in,
  input  wire         io_wr_in,
  input  wire         io_space_in,
  input  wire [7:0]   io_addr_in,
  input  wire [7:0]   io_wdata_in,
  output reg  [7:0]   io_rdata_out,
  output reg          io_hit_out,
  // Timer counters.
  input  wire [1:0]   tick_in,
  input  wire [W-1:0] t1_counter_value_in,
  input  wire [W-1:0] t3_counter_value_in,
  input  wire [1:0]   counter_wr_in,
  // Capture triggers and modes.
  input  wire [1:0]   capture_pin_in,
  input  wire         analog_comp_in,
  input  wire         t1_capture_src_comp_in,
  input  wire [1:0]   capture_rise_in,
  input  wire [1:0]   capture_top_mode_in,
  // Timer 1 compare A/B values kept elsewhere.
  input  wire [W-1:0] t1_compare_a_in,
  input  wire [W-1:0] t1_compare_b_in,
  // Interrupt control.
  input  wire         global_irq_enable_in,
  input  wire [2:0]   vec_ack_in,
  output reg          t1_capture_irq_out,
  output reg          t1_match_a_irq_out,
  output reg          t1_match_b_irq_out,
  // Events and values for the waveform logic.
  output wire [5:0]   match_evt_out,
  output wire [1:0]   capture_evt_out,
  output wire [W-1:0] t1_capture_value_out,
  output wire [W-1:0] t3_capture_value_out,
  output wire [W-1:0] t1_compare_c_out,
  output wire [W-1:0] t3_compare_a_out,
  output wire [W-1:0] t3_compare_b_out,
  output wire [W-1:0] t3_compare_c_out
);

  // --------------------------------------------------------------------------
  // Targets of the address decode
  // --------------------------------------------------------------------------
  localparam [2:0] TG_T1CMPC = 3'h0;
  localparam [2:0] TG_T3CMPA = 3'h1;
  localparam [2:0] TG_T3CMPB = 3'h2;
  localparam [2:0] TG_T3CMPC = 3'h3;
  localparam [2:0] TG_T1CAP  = 3'h4;
  localparam [2:0] TG_T3CAP  = 3'h5;
  localparam [2:0] TG_FLAG   = 3'h6;
  localparam [2:0] TG_MASK   = 3'h7;

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  reg  [7:0]   temp_r;
  reg  [7:0]   mask_r;
  reg  [2:0]   flag_r;
  reg  [2:0]   flag_nxt;
  reg  [W-1:0] cmp_r [0:3];
  integer      i;

  wire [W-1:0] cap_val [0:1];
  wire [1:0]   cap_evt;
  wire [5:0]   match_evt;

  // --------------------------------------------------------------------------
  // Address translation
  // --------------------------------------------------------------------------
  // Short I/O offsets are moved into data space so one decode serves both.
  // Offsets of 0x40 and above from short I/O are not mapped at all, which
  // keeps the extended registers out of reach of those instructions.
  wire [7:0] ds_addr = io_space_in ? (io_addr_in + `TCC_IO_DS_OFS) : io_addr_in; // RL9
  wire       ds_ok   = ~io_space_in | (io_addr_in < `TCC_IO_LIMIT); // RL10

  reg        dec_hit;
  reg        dec_low;
  reg  [2:0] dec_tgt;

  always @* begin
    dec_hit = ds_ok;
    dec_low = 1'b0;
    dec_tgt = TG_T1CMPC;
    case (ds_addr)
      `TCC_IO_T1CAP_L + `TCC_IO_DS_OFS: begin // RL13
        dec_tgt = TG_T1CAP;
        dec_low = 1'b1;
      end
      `TCC_IO_T1CAP_H + `TCC_IO_DS_OFS: begin // RL13
        dec_tgt = TG_T1CAP;
      end
      `TCC_IO_FLAG + `TCC_IO_DS_OFS: begin
        dec_tgt = TG_FLAG;
      end
      `TCC_IO_MASK + `TCC_IO_DS_OFS: begin // RL12
        dec_tgt = TG_MASK;
      end
      `TCC_DS_T1CMPC_L: begin
        dec_tgt = TG_T1CMPC;
        dec_low = 1'b1;
      end
      `TCC_DS_T1CMPC_H: begin
        dec_tgt = TG_T1CMPC;
      end
      `TCC_DS_T3CAP_L: begin
        dec_tgt = TG_T3CAP;
        dec_low = 1'b1;
      end
      `TCC_DS_T3CAP_H: begin
        dec_tgt = TG_T3CAP;
      end
      `TCC_DS_T3CMPC_L: begin
        dec_tgt = TG_T3CMPC;
        dec_low = 1'b1;
      end
      `TCC_DS_T3CMPC_H: begin
        dec_tgt = TG_T3CMPC;
      end
      `TCC_DS_T3CMPB_L: begin
        dec_tgt = TG_T3CMPB;
        dec_low = 1'b1;
      end
      `TCC_DS_T3CMPB_H: begin
        dec_tgt = TG_T3CMPB;
      end
      `TCC_DS_T3CMPA_L: begin
        dec_tgt = TG_T3CMPA;
        dec_low = 1'b1;
      end
      `TCC_DS_T3CMPA_H: begin
        dec_tgt = TG_T3CMPA;
      end
      default: begin
        dec_hit = 1'b0;
      end
    endcase
  end

  wire rd_hit = io_rd_in & dec_hit;
  wire wr_hit = io_wr_in & dec_hit;

  // --------------------------------------------------------------------------
  // Word under access
  // --------------------------------------------------------------------------
  reg [W-1:0] word_sel;

  always @* begin
    case (dec_tgt)
      TG_T1CAP: begin
        word_sel = cap_val[0];
      end
      TG_T3CAP: begin
        word_sel = cap_val[1];
      end
      TG_T1CMPC, TG_T3CMPA, TG_T3CMPB, TG_T3CMPC: begin
        word_sel = cmp_r[dec_tgt[1:0]];
      end
      default: begin
        word_sel = `TCC_RST_WORD;
      end
    endcase
  end

  // --------------------------------------------------------------------------
  // Read data
  // --------------------------------------------------------------------------
  reg [7:0] rd_val;

  always @* begin
    rd_val = `TCC_RST_BYTE;
    if (dec_tgt == TG_MASK) begin
      rd_val = mask_r;
    end else if (dec_tgt == TG_FLAG) begin
      rd_val[`TCC_BIT_CAP]     = flag_r[2];
      rd_val[`TCC_BIT_MATCH_A] = flag_r[1];
      rd_val[`TCC_BIT_MATCH_B] = flag_r[0];
    end else if (dec_low) begin
      rd_val = word_sel[7:0]; // RL4
    end else begin
      rd_val = temp_r; // RL17
    end
  end

  // --------------------------------------------------------------------------
  // Shared high-byte latch and bus answer
  // --------------------------------------------------------------------------
  // Every 16-bit register goes through this one latch, so software must not
  // interleave two 16-bit accesses; the second would overwrite the first.
  wire word_tgt = ~dec_tgt[2] | (dec_tgt == TG_T1CAP) | (dec_tgt == TG_T3CAP);

  always @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      temp_r       <= `TCC_RST_BYTE;
      io_rdata_out <= `TCC_RST_BYTE;
      io_hit_out   <= 1'b0;
    end else begin
      io_hit_out <= rd_hit | wr_hit;
      if (rd_hit) begin
        io_rdata_out <= rd_val;
      end
      if (rd_hit & word_tgt & dec_low) begin
        temp_r <= word_sel[15:8]; // RL5
      end else if (wr_hit & word_tgt & ~dec_low) begin
        temp_r <= io_wdata_in; // RL17
      end
    end
  end

  // --------------------------------------------------------------------------
  // Compare registers
  // --------------------------------------------------------------------------
  wire [W-1:0] wr_word = {temp_r, io_wdata_in};
  wire         wr_low  = wr_hit & dec_low;

  always @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      for (i = 0; i < 4; i = i + 1) begin
        cmp_r[i] <= `TCC_RST_WORD; // RL11
      end
    end else if (wr_low & ~dec_tgt[2]) begin
      cmp_r[dec_tgt[1:0]] <= wr_word; // RL17
    end
  end

  assign t1_compare_c_out = cmp_r[0];
  assign t3_compare_a_out = cmp_r[1];
  assign t3_compare_b_out = cmp_r[2];
  assign t3_compare_c_out = cmp_r[3];

  // --------------------------------------------------------------------------
  // Capture units
  // --------------------------------------------------------------------------
  wire [1:0] cap_src;
  wire [1:0] cap_wr;
  wire [W-1:0] cap_cnt [0:1];

  assign cap_src[0] = t1_capture_src_comp_in ? analog_comp_in : capture_pin_in[0]; // RL2
  assign cap_src[1] = capture_pin_in[1];
  assign cap_wr[0]  = wr_low & (dec_tgt == TG_T1CAP);
  assign cap_wr[1]  = wr_low & (dec_tgt == TG_T3CAP);
  assign cap_cnt[0] = t1_counter_value_in;
  assign cap_cnt[1] = t3_counter_value_in;

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_cap
      tcc_capture #(
        .W (W)
      ) u_cap (
        .clock_in    (clock_in),
        .nrst_in     (nrst_in),
        .src_in      (cap_src[g]),
        .rise_sel_in (capture_rise_in[g]),
        .top_mode_in (capture_top_mode_in[g]),
        .tick_in     (tick_in[g]),
        .counter_in  (cap_cnt[g]),
        .wr_in       (cap_wr[g]),
        .wr_data_in  (wr_word),
        .value_out   (cap_val[g]),
        .event_out   (cap_evt[g])
      );
    end
  endgenerate

  assign t1_capture_value_out = cap_val[0]; // RL3
  assign t3_capture_value_out = cap_val[1];
  assign capture_evt_out      = cap_evt;

  // --------------------------------------------------------------------------
  // Compare units: 0..2 are timer 1 A/B/C, 3..5 are timer 3 A/B/C
  // --------------------------------------------------------------------------
  wire [6*W-1:0] cmp_bus = {cmp_r[3], cmp_r[2], cmp_r[1],
                            cmp_r[0], t1_compare_b_in, t1_compare_a_in};

  generate
    for (g = 0; g < 6; g = g + 1) begin : g_match
      tcc_match #(
        .W (W)
      ) u_match (
        .clock_in   (clock_in),
        .nrst_in    (nrst_in),
        .tick_in    (tick_in[g/3]),
        .counter_in (cap_cnt[g/3]),
        .compare_in (cmp_bus[g*W +: W]),
        .block_in   (counter_wr_in[g/3]),
        .match_out  (match_evt[g])
      );
    end
  endgenerate

  assign match_evt_out = match_evt;

  // --------------------------------------------------------------------------
  // Timer 1 flags, mask and interrupt requests
  // --------------------------------------------------------------------------
  // A set in the same cycle as a clear wins, so no event is ever lost.
  wire       flag_wr = wr_hit & (dec_tgt == TG_FLAG);
  wire [2:0] flag_set = {cap_evt[0], match_evt[0], match_evt[1]};
  wire [2:0] flag_clr = vec_ack_in | ({3{flag_wr}} &
                        {io_wdata_in[`TCC_BIT_CAP], io_wdata_in[`TCC_BIT_MATCH_A],
                         io_wdata_in[`TCC_BIT_MATCH_B]});

  always @* begin
    flag_nxt = flag_set | (flag_r & ~flag_clr); // RL14
  end

  always @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      flag_r             <= 3'h0;
      mask_r             <= `TCC_RST_BYTE; // RL12
      t1_capture_irq_out <= 1'b0;
      t1_match_a_irq_out <= 1'b0;
      t1_match_b_irq_out <= 1'b0;
    end else begin
      flag_r <= flag_nxt;
      if (wr_hit & (dec_tgt == TG_MASK)) begin
        mask_r <= io_wdata_in;
      end
      t1_capture_irq_out <= flag_r[2] & mask_r[`TCC_BIT_CAP] & global_irq_enable_in; // RL6
      t1_match_a_irq_out <= flag_r[1] & mask_r[`TCC_BIT_MATCH_A] & global_irq_enable_in; // RL7
      t1_match_b_irq_out <= flag_r[0] & mask_r[`TCC_BIT_MATCH_B] & global_irq_enable_in; // RL8
    end
  end

endmodule // tcc_regs
`default_nettype wire

// File: tcc_defs.vh
// Constants for the timer capture/compare register block.
// Assumes inclusion by bare name from every design file of the block.
`ifndef TCC_DEFS_VH
`define TCC_DEFS_VH

// ----------------------------------------------------------------------------
// Address spaces
// ----------------------------------------------------------------------------
// Short I/O offsets map to data space at this distance.
`define TCC_IO_DS_OFS    8'h20
// First offset that short I/O instructions can no longer reach.
`define TCC_IO_LIMIT     8'h40

// ----------------------------------------------------------------------------
// Low I/O registers, given as short I/O offsets
// ----------------------------------------------------------------------------
`define TCC_IO_T1CAP_L   8'h26
`define TCC_IO_T1CAP_H   8'h27
`define TCC_IO_FLAG      8'h36
`define TCC_IO_MASK      8'h37

// ----------------------------------------------------------------------------
// Extended registers, given as data-space addresses
// ----------------------------------------------------------------------------
`define TCC_DS_T1CMPC_L  8'h78
`define TCC_DS_T1CMPC_H  8'h79
`define TCC_DS_T3CAP_L   8'h80
`define TCC_DS_T3CAP_H   8'h81
`define TCC_DS_T3CMPC_L  8'h82
`define TCC_DS_T3CMPC_H  8'h83
`define TCC_DS_T3CMPB_L  8'h84
`define TCC_DS_T3CMPB_H  8'h85
`define TCC_DS_T3CMPA_L  8'h86
`define TCC_DS_T3CMPA_H  8'h87

// ----------------------------------------------------------------------------
// Bit positions in the mask and flag registers
// ----------------------------------------------------------------------------
`define TCC_BIT_CAP      5
`define TCC_BIT_MATCH_A  4
`define TCC_BIT_MATCH_B  3

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define TCC_RST_BYTE     8'h00
`define TCC_RST_WORD     16'h0000

`endif

// File: tcc_match.v
// One compare unit: flags a match one timer tick after equality.
// Assumes tick_in is a one-cycle enable and block_in marks a counter write.
`timescale 1ns/1ps
`default_nettype none
`include "tcc_defs.vh"

module tcc_match #(
  parameter W = 16
) (
  // Clock and reset.
  input  wire         clock_in,
  input  wire         nrst_in,
  // Timer side.
  input  wire         tick_in,
  input  wire [W-1:0] counter_in,
  input  wire [W-1:0] compare_in,
  input  wire         block_in,
  // Match event.
  output reg          match_out
);

  reg pend_r;
  reg blk_r;

  // A counter write holds off the equality seen at the next tick and at any tick in its own cycle.
  always @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pend_r    <= 1'b0;
      blk_r     <= 1'b0;
      match_out <= 1'b0;
    end else begin
      match_out <= 1'b0;
      if (block_in) begin
        blk_r <= 1'b1; // RL16
      end
      if (tick_in) begin
        match_out <= pend_r; // RL15
        pend_r    <= (counter_in == compare_in) & ~blk_r & ~block_in; // RL16
        blk_r     <= block_in;
      end
    end
  end

endmodule // tcc_match
`default_nettype wire

// File: tcc_capture.v
// One input-capture register with edge detection and top-limit match.
// Assumes the trigger is already synchronous and software writes arrive whole.
`timescale 1ns/1ps
`default_nettype none
`include "tcc_defs.vh"

module tcc_capture #(
  parameter W = 16
) (
  // Clock and reset.
  input  wire         clock_in,
  input  wire         nrst_in,
  // Trigger and mode.
  input  wire         src_in,
  input  wire         rise_sel_in,
  input  wire         top_mode_in,
  input  wire         tick_in,
  input  wire [W-1:0] counter_in,
  // Software write.
  input  wire         wr_in,
  input  wire [W-1:0] wr_data_in,
  // Results.
  output reg  [W-1:0] value_out,
  output reg          event_out
);

  reg  prev_r;
  wire edge_hit = rise_sel_in ? (src_in & ~prev_r) : (~src_in & prev_r);
  wire top_hit  = tick_in & top_mode_in & (counter_in == value_out);

  // In top mode the register is the limit, so pin edges must not move it.
  always @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      prev_r    <= 1'b0;
      value_out <= `TCC_RST_WORD; // RL11
      event_out <= 1'b0;
    end else begin
      prev_r    <= src_in;
      event_out <= (edge_hit & ~top_mode_in) | top_hit; // RL14
      if (edge_hit & ~top_mode_in) begin
        value_out <= counter_in; // RL1
      end else if (wr_in) begin
        value_out <= wr_data_in; // RL3
      end
    end
  end

endmodule // tcc_capture
`default_nettype wire

// File: tcc_regs_sva.sv
// Concurrent checks on the ports of the timer capture/compare block.
// Assumes it is bound to tcc_regs and sees nothing but its ports.
`timescale 1ns/1ps
`default_nettype none

module tcc_regs_sva #(
  parameter W = 16
) (
  // Clock and reset.
  input wire logic         clock_in,
  input wire logic         nrst_in,
  // Register bus.
  input wire logic         io_rd_in,
  input wire logic         io_wr_in,
  input wire logic         io_space_in,
  input wire logic [7:0]   io_addr_in,
  input wire logic [7:0]   io_rdata_out,
  input wire logic         io_hit_out,
  // Timers and captures.
  input wire logic [1:0]   tick_in,
  input wire logic [W-1:0] t3_counter_value_in,
  input wire logic [1:0]   capture_pin_in,
  input wire logic [1:0]   capture_rise_in,
  input wire logic [1:0]   capture_top_mode_in,
  input wire logic [5:0]   match_evt_out,
  input wire logic [1:0]   capture_evt_out,
  input wire logic [W-1:0] t3_capture_value_out,
  // Interrupts.
  input wire logic         global_irq_enable_in,
  input wire logic         t1_capture_irq_out,
  input wire logic         t1_match_a_irq_out,
  input wire logic         t1_match_b_irq_out
);
  // ----
  // Properties
  // ----
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!nrst_in);
  wire strobe = io_rd_in | io_wr_in;

  // The reset qualifier keeps the edge detector quiet on the first edge out of reset.
  sequence s_t3_rise;
    $past(nrst_in) && !capture_top_mode_in[1] && capture_rise_in[1] && capture_pin_in[1] && !$past(capture_pin_in[1]);
  endsequence
  sequence s_t3_load;
    capture_evt_out[1] && (t3_capture_value_out == $past(t3_counter_value_in));
  endsequence

  property p_t3_capture; s_t3_rise |=> s_t3_load; endproperty
  property p_ext_io; strobe && io_space_in && io_addr_in >= 8'h40 |=> !io_hit_out; endproperty
  property p_mask_ds; strobe && !io_space_in && io_addr_in == 8'h57 |=> io_hit_out; endproperty
  property p_cap_io; strobe && io_space_in && io_addr_in[7:1] == 7'h13 |=> io_hit_out; endproperty
  property p_idle; !strobe |=> !io_hit_out; endproperty
  property p_rd_hold; !io_rd_in |=> $stable(io_rdata_out); endproperty
  property p_match_tick; |match_evt_out[2:0] |-> $past(tick_in[0]); endproperty
  property p_irq_cap; !global_irq_enable_in |=> !t1_capture_irq_out; endproperty
  property p_irq_a; !global_irq_enable_in |=> !t1_match_a_irq_out; endproperty
  property p_irq_b; !global_irq_enable_in |=> !t1_match_b_irq_out; endproperty

  a_t3_capture: assert property (p_t3_capture) else $error("capture did not load counter");
  a_ext_io: assert property (p_ext_io) else $error("short access above 0x3F taken");
  a_mask_ds: assert property (p_mask_ds) else $error("mask not decoded at 0x57");
  a_cap_io: assert property (p_cap_io) else $error("capture not decoded at 0x26");
  a_idle: assert property (p_idle) else $error("hit without access");
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  a_match_tick: assert property (p_match_tick) else $error("match off tick");
  a_irq_cap: assert property (p_irq_cap) else $error("capture request unmasked");
  a_irq_a: assert property (p_irq_a) else $error("match A request unmasked");
  a_irq_b: assert property (p_irq_b) else $error("match B request unmasked");
endmodule // tcc_regs_sva

bind tcc_regs tcc_regs_sva #(.W(W)) u_sva (
  .clock_in, .nrst_in, .io_rd_in, .io_wr_in, .io_space_in, .io_addr_in, .io_rdata_out, .io_hit_out,
  .tick_in, .t3_counter_value_in, .capture_pin_in, .capture_rise_in, .capture_top_mode_in,
  .match_evt_out, .capture_evt_out, .t3_capture_value_out, .global_irq_enable_in,
  .t1_capture_irq_out, .t1_match_a_irq_out, .t1_match_b_irq_out
);
`default_nettype wire

// File: tcc_tb.sv
// Self-checking bench for the timer capture/compare register block.
// Assumes the design and its bound checker are compiled before it.
`timescale 1ns/1ps
`default_nettype none

`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin mismatches++; \
  $display("MISMATCH %s expected %h seen %h", n, e, s); end end

module testbench;
  logic        clock_in = 0, nrst_in = 0, io_rd_in = 0, io_wr_in = 0, io_space_in = 0;
  logic        analog_comp_in = 0, t1_capture_src_comp_in = 0, global_irq_enable_in = 0;
  logic [7:0]  io_addr_in = 0, io_wdata_in = 0, io_rdata_out, rdv;
  logic [1:0]  tick_in = 0, counter_wr_in = 0, capture_pin_in = 0, capture_top_mode_in = 0;
  logic [1:0]  capture_rise_in = 2'h3, capture_evt_out;
  logic [2:0]  vec_ack_in = 0;
  logic [5:0]  match_evt_out;
  logic [15:0] t1_counter_value_in = 0, t3_counter_value_in = 0, t1_compare_a_in = 0, t1_compare_b_in = 0;
  logic [15:0] t1_capture_value_out, t3_capture_value_out, t1_compare_c_out, v, got;
  logic [15:0] t3_compare_a_out, t3_compare_b_out, t3_compare_c_out, vals [6];
  logic        io_hit_out, t1_capture_irq_out, t1_match_a_irq_out, t1_match_b_irq_out, hit;
  logic [7:0]  lows [6] = '{8'h46, 8'h78, 8'h80, 8'h82, 8'h84, 8'h86};
  int          mismatches = 0, comparisons = 0;
  int unsigned seed_v;

  tcc_regs uut (.clock_in, .nrst_in, .io_rd_in, .io_wr_in, .io_space_in, .io_addr_in, .io_wdata_in,
    .io_rdata_out, .io_hit_out, .tick_in, .t1_counter_value_in, .t3_counter_value_in, .counter_wr_in,
    .capture_pin_in, .analog_comp_in, .t1_capture_src_comp_in, .capture_rise_in, .capture_top_mode_in,
    .t1_compare_a_in, .t1_compare_b_in, .global_irq_enable_in, .vec_ack_in, .t1_capture_irq_out,
    .t1_match_a_irq_out, .t1_match_b_irq_out, .match_evt_out, .capture_evt_out, .t1_capture_value_out,
    .t3_capture_value_out, .t1_compare_c_out, .t3_compare_a_out, .t3_compare_b_out, .t3_compare_c_out);

  always #12.5 clock_in = ~clock_in;

  // ----
  // Bus helpers
  // ----
  // Entered at a falling edge; an idle cycle follows so strobes never toggle twice in one step.
  task automatic bus(input logic rd, input logic [7:0] a, d, input logic sp = 1'b0);
    io_rd_in = rd;
    io_wr_in = !rd;
    io_space_in = sp;
    io_addr_in = a;
    io_wdata_in = d;
    @(negedge clock_in);
    hit = io_hit_out;
    rdv = io_rdata_out;
    io_rd_in = 0;
    io_wr_in = 0;
    @(negedge clock_in);
  endtask
  task automatic wr16(input logic [7:0] a, input logic [15:0] d);
    bus(0, a + 8'h01, d[15:8]);
    bus(0, a, d[7:0]);
  endtask
  task automatic rd16(input logic [7:0] a);
    bus(1, a, 8'h00);
    got[7:0] = rdv;
    bus(1, a + 8'h01, 8'h00);
    got[15:8] = rdv;
  endtask
  function automatic logic [15:0] port(input logic [7:0] a);
    case (a)
      8'h46: port = t1_capture_value_out;
      8'h78: port = t1_compare_c_out;
      8'h80: port = t3_capture_value_out;
      8'h82: port = t3_compare_c_out;
      8'h84: port = t3_compare_b_out;
      default: port = t3_compare_a_out;
    endcase
  endfunction
  function automatic logic [7:0] flags(input logic c, m);
    flags = {2'b00, c, m, m, 3'b000};
  endfunction
  task automatic results;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // ----
  // Scenarios
  // ----
  initial begin
    #125000;
    mismatches++;
    results;
  end

  initial begin
    seed_v = $urandom(20);
    repeat (6) @(negedge clock_in);
    nrst_in = 1;
    foreach (lows[i]) begin
      rd16(lows[i]);
      `CHK("reset", 16'h0000, got)
      vals[i] = $urandom;
      wr16(lows[i], vals[i]);
      `CHK("port", vals[i], port(lows[i]))
      rd16(lows[i]);
      `CHK("readback", vals[i], got)
    end
    bus(1, 8'h57, 8'h00);
    `CHK("mask reset", 8'h00, rdv)
    v = $urandom;
    bus(0, 8'h37, v[7:0], 1);
    `CHK("io hit", 1'b1, hit)
    bus(1, 8'h57, 8'h00);
    `CHK("mask", v[7:0], rdv)
    bus(0, 8'h57, 8'h38);
    bus(1, 8'h26, 8'h00, 1);
    bus(1, 8'h27, 8'h00, 1);
    `CHK("t1 cap io", vals[0][15:8], rdv)
    bus(0, 8'h87, 8'hA5);
    rd16(8'h80);
    bus(0, 8'h86, 8'h5A);
    `CHK("shared latch", {vals[2][15:8], 8'h5A}, t3_compare_a_out)
    bus(0, 8'h78, 8'hFF, 1);
    `CHK("ext io hit", 1'b0, hit)
    bus(0, 8'h60, 8'hFF);
    `CHK("unmapped hit", 1'b0, hit)
    `CHK("ext io", vals[1], t1_compare_c_out)
    repeat (4) begin
      v = $urandom;
      t3_counter_value_in = v;
      capture_pin_in[1] = 1;
      @(negedge clock_in);
      `CHK("t3 evt", 2'b10, capture_evt_out)
      `CHK("t3 cap", v, t3_capture_value_out)
      t3_counter_value_in = ~v;
      capture_pin_in[1] = 0;
      repeat (2) @(negedge clock_in);
      `CHK("t3 fall", v, t3_capture_value_out)
    end
    global_irq_enable_in = 1;
    t1_capture_src_comp_in = 1;
    capture_rise_in[0] = 0;
    analog_comp_in = 1;
    v = $urandom;
    t1_counter_value_in = v;
    capture_pin_in[0] = 1;
    @(negedge clock_in);
    capture_pin_in[0] = 0;
    @(negedge clock_in);
    `CHK("pin ignored", vals[0], t1_capture_value_out)
    analog_comp_in = 0;
    @(negedge clock_in);
    `CHK("comp cap", v, t1_capture_value_out)
    repeat (2) @(negedge clock_in);
    `CHK("cap irq", 1'b1, t1_capture_irq_out)
    global_irq_enable_in = 0;
    @(negedge clock_in);
    `CHK("cap gate", 1'b0, t1_capture_irq_out)
    global_irq_enable_in = 1;
    bus(1, 8'h56, 8'h00);
    `CHK("cap flag", flags(1, 0), rdv)
    vec_ack_in = 3'h4;
    @(negedge clock_in);
    vec_ack_in = 3'h0;
    bus(1, 8'h56, 8'h00);
    `CHK("vec clear", 8'h00, rdv)
    capture_top_mode_in[0] = 1;
    tick_in[0] = 1;
    @(negedge clock_in);
    tick_in[0] = 0;
    `CHK("top evt", 2'b01, capture_evt_out)
    // The flag lands one cycle after the event; clearing earlier would lose to the set.
    @(negedge clock_in);
    bus(1, 8'h56, 8'h00);
    `CHK("top flag", flags(1, 0), rdv)
    bus(0, 8'h56, 8'h20);
    bus(1, 8'h56, 8'h00);
    `CHK("w1 clear", 8'h00, rdv)
    capture_top_mode_in[0] = 0;
    for (int b = 0; b < 2; b++) begin
      v = $urandom;
      t1_compare_a_in = v;
      t1_compare_b_in = v;
      t1_counter_value_in = v - 16'h0001;
      counter_wr_in[0] = b[0];
      @(negedge clock_in);
      counter_wr_in[0] = 0;
      tick_in[0] = 1;
      t1_counter_value_in = v;
      @(negedge clock_in);
      tick_in[0] = 0;
      @(negedge clock_in);
      tick_in[0] = 1;
      t1_counter_value_in = v + 16'h0001;
      @(negedge clock_in);
      tick_in[0] = 0;
      `CHK("match", {2{!b[0]}}, match_evt_out[1:0])
      repeat (2) @(negedge clock_in);
      `CHK("match irq", {2{!b[0]}}, {t1_match_a_irq_out, t1_match_b_irq_out})
      global_irq_enable_in = 0;
      @(negedge clock_in);
      `CHK("match gate", 2'b00, {t1_match_a_irq_out, t1_match_b_irq_out})
      global_irq_enable_in = 1;
      bus(1, 8'h56, 8'h00);
      `CHK("match flags", flags(0, !b[0]), rdv)
      bus(0, 8'h56, 8'h38);
    end
    t3_counter_value_in = vals[3];
    tick_in[1] = 1;
    @(negedge clock_in);
    t3_counter_value_in = ~vals[3];
    tick_in[1] = 0;
    @(negedge clock_in);
    tick_in[1] = 1;
    @(negedge clock_in);
    tick_in[1] = 0;
    `CHK("t3 match", 6'h20, match_evt_out)
    results;
  end
endmodule // testbench
`default_nettype wire
